// *** inc/vtm_defs.vh ***
// Behaviour
// - Each serial start samples the address pin; its wiring sets two address bits.
// - Voltage results are 8 bits; temperature is 11 bits at default resolution.
// - Byte read of temperature returns its upper eight bits.
// - Word read gives 11-bit temperature left-justified; lowest five bits are ignored.
// - Config bit 5 gives 9-bit temperature and a four times shorter cycle.
// - Temperature weights: 1 deg byte, 0.125 deg 11-bit, 0.5 deg 9-bit.
// - Nominal input voltage converts to three quarters of full scale, code 192.
// - Writing one to config bit 0 starts the conversion cycle.
// - Order: temperature, mid rail, low rail, high rail, own supply.
// - A stop request lets the running cycle finish and store all results.
// - Every restart begins with the temperature conversion.
// - Interrupt on temperature above hot limit or voltage outside its limits.
// - Interrupt pulls alert low and sets status bit 0 to 4 of the channel.
// - Status read releases alert, except comparator-mode temperature alerts.
// - Status read clears its bits, except comparator-mode temperature bits.
// - Full cycle takes typically 200 ms, at most 300 ms, at default resolution.
`ifndef VTM_DEFS_VH
`define VTM_DEFS_VH

`define CLK_KHZ        50000
`define CYCLE_TYP_MS   200
`define CYCLE_MAX_MS   300
`define NUM_CH         5
`define FAST_DIV       4

`define IDX_MID_DATA   7'h20
`define IDX_LOW_DATA   7'h21
`define IDX_HIGH_DATA  7'h22
`define IDX_VCC_DATA   7'h23
`define IDX_TEMP_WORD  7'h27
`define IDX_TEMP_BYTE  7'h28
`define IDX_LIM_FIRST  7'h2B
`define IDX_LIM_LAST   7'h32
`define IDX_HOT_LIM    7'h39
`define IDX_CONFIG     7'h40
`define IDX_STATUS     7'h41
`define IDX_MASK       7'h42
`define IDX_LINK       7'h43

`define CFG_RUN        0
`define CFG_CMP        1
`define CFG_FAST       5

`define HI_LIM_RST     8'hD3
`define LO_LIM_RST     8'hAD
`define HOT_LIM_RST    8'h50
`define NOMINAL_CODE   8'hC0

`define ADDSEL_GND     2'h0
`define ADDSEL_VCC     2'h1
`define ADDSEL_SDA     2'h2
`define ADDSEL_SCL     2'h3

`define CH_TEMP        3'h0
`define CH_VCC         3'h4
`define TEMP_LSB_PAD   5
`define FINE_DROP      2

`endif

// *** rtl/voltage_temp_monitor_sequencer.v ***
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "vtm_defs.vh"

module voltage_temp_monitor_sequencer #(
  parameter CYCLE_CLKS = `CYCLE_TYP_MS * `CLK_KHZ
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire [10:0] adc_code,
  output reg  [2:0]  adc_channel,
  output reg         adc_fine,
  output reg         busy,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_n,
  input  wire        add_in,
  input  wire        alert_in,
  output reg         alert_out,
  output reg         alert_oe_n,
  output reg  [1:0]  addr_lsb
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;
  localparam [23:0] SLOT_CLKS = CYCLE_CLKS / `NUM_CH;
  localparam [23:0] SLOT_FAST = SLOT_CLKS / `FAST_DIV;

  function [7:0] word_of;
    input [6:0] idx;
    begin
      word_of = {1'b0, idx};
    end
  endfunction

  function is_limit;
    input [6:0] idx;
    begin
      is_limit = (idx >= `IDX_LIM_FIRST) && (idx <= `IDX_LIM_LAST);
    end
  endfunction

  reg  [1:0]  state;
  reg  [23:0] timer;
  reg  [2:0]  ch;
  reg  [7:0]  cfg;
  reg  [7:0]  status;
  reg  [7:0]  mask;
  reg  [7:0]  hot_lim;
  reg  [10:0] temp;
  reg         alert_pend;
  reg  [7:0]  volt   [0:3];
  reg  [7:0]  hi_lim [0:3];
  reg  [7:0]  lo_lim [0:3];
  reg  [2:0]  scl_s;
  reg  [2:0]  sda_s;
  reg  [2:0]  add_s;
  reg  [1:0]  alert_s;
  reg         add_wait;

  wire [6:0]  idx      = paddr[8:2];
  wire        mapped_hi = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  wire        lim_hit  = is_limit(idx);
  wire [2:0]  lim_off  = idx[2:0] - 3'h3;
  wire [1:0]  lim_ch   = lim_off[2:1];
  wire        lim_lo   = lim_off[0];
  wire        xfer     = psel & penable & pready;
  wire        do_wr    = xfer & pwrite & ~pslverr;
  wire        rd_stat  = xfer & ~pwrite & (idx == `IDX_STATUS) & ~pslverr;
  wire        wr_stat  = do_wr & (idx == `IDX_STATUS);
  wire        cmp_mode = cfg[`CFG_CMP];
  wire        fast     = cfg[`CFG_FAST];
  wire [23:0] slot_len = fast ? SLOT_FAST : SLOT_CLKS;
  wire        slot_end = (state == ST_RUN) && (timer == slot_len - 24'h1);
  wire [10:0] temp_new = fast ? {adc_code[10:2], 2'h0} : adc_code;
  wire [1:0]  vch      = ch[1:0] - 2'h1;
  wire        temp_over = $signed(temp_new[10:3]) > $signed(hot_lim);
  wire        volt_bad = (adc_code[10:3] > hi_lim[vch]) || (adc_code[10:3] < lo_lim[vch]);
  wire [4:0]  ev;
  wire        start_det = scl_s[1] & sda_s[2] & ~sda_s[1];
  wire        scl_fall  = scl_s[2] & ~scl_s[1];

  assign ev = !slot_end ? 5'h0 :
              (ch == `CH_TEMP) ? {4'h0, temp_over} :
              (volt_bad ? (5'h1 << ch) : 5'h0);

  reg  [7:0]  next_status;
  reg         next_alert;
  reg  [31:0] rd_word;
  reg         rd_ok;

  // Pin inputs pass two flops before any logic reads them
  always @(posedge sys_clk) begin
    if (!rstn) begin
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
      add_s   <= 3'h0;
      alert_s <= 2'h3;
    end else begin
      scl_s   <= {scl_s[1:0], scl_in};
      sda_s   <= {sda_s[1:0], sda_in};
      add_s   <= {add_s[1:0], add_in};
      alert_s <= {alert_s[0], alert_in};
    end
  end

  // Strap decode: SDA and SCL wiring show as the pin tracking that line
  always @(posedge sys_clk) begin
    if (!rstn) begin
      addr_lsb <= `ADDSEL_GND;
      add_wait <= 1'b0;
    end else if (start_det) begin
      if (!add_s[1])
        addr_lsb <= add_s[2] ? `ADDSEL_SDA : `ADDSEL_GND;
      add_wait <= add_s[1];
    end else if (add_wait && scl_fall) begin
      addr_lsb <= add_s[1] ? `ADDSEL_VCC : `ADDSEL_SCL;
      add_wait <= 1'b0;
    end
  end

  // Serial protocol engine lives outside; the line is left released
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
  end

  // Sequencer
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      timer       <= 24'h0;
      ch          <= `CH_TEMP;
      adc_channel <= `CH_TEMP;
      adc_fine    <= 1'b1;
      busy        <= 1'b0;
    end else begin
      adc_fine <= ~fast;
      case (state)
        ST_IDLE: begin
          timer <= 24'h0;
          ch    <= `CH_TEMP;
          if (cfg[`CFG_RUN]) begin
            state <= ST_RUN;
            busy  <= 1'b1;
          end else begin
            busy <= 1'b0;
          end
        end
        ST_RUN: begin
          if (slot_end) begin
            timer <= 24'h0;
            if (ch == `CH_VCC) begin
              ch <= `CH_TEMP;
              if (!cfg[`CFG_RUN]) begin
                state <= ST_IDLE;
                busy  <= 1'b0;
              end
            end else begin
              ch <= ch + 3'h1;
            end
          end else begin
            timer <= timer + 24'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      adc_channel <= (state == ST_RUN && slot_end) ?
                     ((ch == `CH_VCC) ? `CH_TEMP : ch + 3'h1) :
                     ((state == ST_IDLE) ? `CH_TEMP : ch);
    end
  end

  // Result capture
  always @(posedge sys_clk) begin
    if (!rstn) begin
      temp <= 11'h0;
      volt[0] <= 8'h0;
      volt[1] <= 8'h0;
      volt[2] <= 8'h0;
      volt[3] <= 8'h0;
    end else if (slot_end) begin
      if (ch == `CH_TEMP)
        temp <= temp_new;
      else
        volt[vch] <= adc_code[10:3];
    end
  end

  // Status: set wins over read or write clear
  always @* begin
    next_status = status;
    if (rd_stat)
      next_status = cmp_mode ? (status & 8'h01) : 8'h00;
    if (wr_stat)
      next_status = next_status & ~(pwdata[7:0] & (cmp_mode ? 8'hFE : 8'hFF));
    next_status = next_status | {3'h0, ev};
    if (cmp_mode && slot_end && ch == `CH_TEMP)
      next_status[0] = temp_over;
  end

  always @* begin
    next_alert = alert_pend;
    if (rd_stat)
      next_alert = 1'b0;
    if (|(cmp_mode ? {ev[4:1], 1'b0} : ev))
      next_alert = 1'b1;
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      status     <= 8'h0;
      alert_pend <= 1'b0;
      alert_out  <= 1'b0;
      alert_oe_n <= 1'b1;
      irq        <= 1'b0;
    end else begin
      status     <= next_status;
      alert_pend <= next_alert;
      alert_out  <= 1'b0;
      alert_oe_n <= ~(next_alert | (cmp_mode & next_status[0]));
      irq        <= |(next_status & mask);
    end
  end

  // Read mux
  always @* begin
    rd_word = 32'h0;
    rd_ok   = mapped_hi;
    if (lim_hit)
      rd_word[7:0] = lim_lo ? lo_lim[lim_ch] : hi_lim[lim_ch];
    else begin
      case (idx)
        `IDX_MID_DATA, `IDX_LOW_DATA, `IDX_HIGH_DATA, `IDX_VCC_DATA: begin
          rd_word[7:0] = volt[idx[1:0]];
        end
        `IDX_TEMP_WORD: begin
          rd_word[15:0] = {temp, {`TEMP_LSB_PAD{1'b0}}};
        end
        `IDX_TEMP_BYTE: begin
          rd_word[7:0] = temp[10:3];
        end
        `IDX_HOT_LIM: begin
          rd_word[7:0] = hot_lim;
        end
        `IDX_CONFIG: begin
          rd_word[7:0] = cfg;
        end
        `IDX_STATUS: begin
          rd_word[7:0] = status;
        end
        `IDX_MASK: begin
          rd_word[7:0] = mask;
        end
        `IDX_LINK: begin
          rd_word[7:0] = {busy, adc_channel, ~alert_s[1], 1'b0, addr_lsb};
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  // APB: answer registered in setup, ready in the single access cycle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        pslverr <= ~rd_ok;
        prdata  <= (pwrite || !rd_ok) ? 32'h0 : rd_word;
      end else if (xfer) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0;
      end
    end
  end

  // Software writable registers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cfg     <= 8'h0;
      mask    <= 8'h0;
      hot_lim <= `HOT_LIM_RST;
      hi_lim[0] <= `HI_LIM_RST;
      hi_lim[1] <= `HI_LIM_RST;
      hi_lim[2] <= `HI_LIM_RST;
      hi_lim[3] <= `HI_LIM_RST;
      lo_lim[0] <= `LO_LIM_RST;
      lo_lim[1] <= `LO_LIM_RST;
      lo_lim[2] <= `LO_LIM_RST;
      lo_lim[3] <= `LO_LIM_RST;
    end else if (do_wr) begin
      if (lim_hit) begin
        if (lim_lo)
          lo_lim[lim_ch] <= pwdata[7:0];
        else
          hi_lim[lim_ch] <= pwdata[7:0];
      end else if (idx == `IDX_CONFIG)
        cfg <= pwdata[7:0];
      else if (idx == `IDX_MASK)
        mask <= pwdata[7:0];
      else if (idx == `IDX_HOT_LIM)
        hot_lim <= pwdata[7:0];
    end
  end

endmodule

`default_nettype wire

// *** verification/voltage_temp_monitor_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vtm_defs.vh"
module voltage_temp_monitor_sequencer_test;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, adc_fine, busy, err;
  logic        sda_out, sda_oe_n, alert_out, alert_oe_n, scl, sda, add;
  logic [10:0] adc_code;
  logic [2:0]  adc_channel;
  logic [1:0]  addr_lsb;
  logic [54:0] codes = 55'h0;
  wire         sda_w = sda & (sda_oe_n | sda_out);
  int          mismatches = 0;
  int          tests_run = 0;
  always #10 sys_clk = ~sys_clk;
  voltage_temp_monitor_sequencer #(.CYCLE_CLKS(100)) u_voltage_temp_monitor_sequencer (
    .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .adc_code, .adc_channel, .adc_fine, .busy, .scl_in(scl), .sda_in(sda_w), .sda_out,
    .sda_oe_n, .add_in(add), .alert_in(alert_oe_n), .alert_out, .alert_oe_n, .addr_lsb);
  vtm_far_side u_vtm_far_side (.adc_channel, .codes, .adc_code, .scl, .sda, .add);
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [6:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, e);
  endtask
  // Partial first cycle possible, so callers ask for two ends when it matters
  task wait_end(input int k);
    int n;
    n = 0;
    repeat (k) begin
      while (adc_channel !== 3'h4 && n < 3000) begin
        @(posedge sys_clk);
        n++;
      end
      while (adc_channel === 3'h4 && busy === 1'b1 && n < 3000) begin
        @(posedge sys_clk);
        n++;
      end
    end
    repeat (2) @(posedge sys_clk);
    #1 chk(n < 3000, 1'b1);
  endtask
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      rdc(7'h2B + k[6:0], k[0] ? `LO_LIM_RST : `HI_LIM_RST);
    end
    rdc(`IDX_HOT_LIM, `HOT_LIM_RST);
    rdc(7'h01, 32'h0);
    chk(err, 1'b1);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      u_vtm_far_side.frame(s[1:0]);
      @(posedge sys_clk);
      apb(1'b0, `IDX_LINK, 8'h00);
      chk({rd[1:0], addr_lsb}, {s[1:0], s[1:0]});
    end
    $display("test strap done");
    codes <= {11'h600, 11'h560, 11'h6A0, 11'h600, 11'h2A5};
    apb(1'b1, `IDX_MASK, 8'h1F);
    apb(1'b1, `IDX_CONFIG, 8'h01);
    apb(1'b1, `IDX_CONFIG, 8'h00);
    wait_end(1);
    chk(busy, 1'b0);
    rdc(`IDX_MID_DATA, 32'hC0);
    rdc(`IDX_LOW_DATA, 32'hD4);
    rdc(`IDX_HIGH_DATA, 32'hAC);
    rdc(`IDX_VCC_DATA, 32'hC0);
    rdc(`IDX_TEMP_WORD, 32'h54A0);
    rdc(`IDX_TEMP_BYTE, 32'h54);
    #1 chk({irq, alert_oe_n}, 2'b10);
    rdc(`IDX_STATUS, 32'h0D);
    #1 chk({irq, alert_oe_n}, 2'b01);
    rdc(`IDX_STATUS, 32'h00);
    $display("test single cycle done");
    codes <= {11'h600, 11'h600, 11'h600, 11'h600, 11'h2A5};
    apb(1'b1, `IDX_CONFIG, 8'h23);
    wait_end(2);
    chk(adc_fine, 1'b0);
    apb(1'b0, `IDX_TEMP_WORD, 8'h00);
    chk(rd & 32'hFF80, 32'h5480);
    rdc(`IDX_STATUS, 32'h01);
    apb(1'b1, `IDX_MASK, 8'h00);
    #1 chk({irq, alert_oe_n}, 2'b00);
    rdc(`IDX_STATUS, 32'h01);
    codes <= {11'h600, 11'h600, 11'h600, 11'h600, 11'h100};
    wait_end(2);
    chk(alert_oe_n, 1'b1);
    rdc(`IDX_STATUS, 32'h00);
    apb(1'b1, `IDX_CONFIG, 8'h00);
    wait_end(1);
    chk(busy, 1'b0);
    apb(1'b1, `IDX_CONFIG, 8'h01);
    #1 chk({busy, adc_channel}, 4'h8);
    $display("test comparator done");
    complete_run;
  end
endmodule
`default_nettype wire

// *** verification/vtm_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module vtm_checker (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       irq,
  input wire logic [2:0] adc_channel,
  input wire logic       busy,
  input wire logic       alert_out,
  input wire logic       alert_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_order;
    $changed(adc_channel) |-> adc_channel == $past(adc_channel) + 3'h1 || adc_channel == 3'h0;
  endproperty
  a_order: assert property (p_order) else $error("channel out of order");
  property p_restart; $rose(busy) |-> adc_channel == 3'h0; endproperty
  a_restart: assert property (p_restart) else $error("run not begun on channel 0");
  property p_stop; $fell(busy) |-> $past(adc_channel) == 3'h4; endproperty
  a_stop: assert property (p_stop) else $error("run ended before last channel");
  // Shortest slot is the fast one, five clocks with the bench setting
  property p_slot; $changed(adc_channel) |=> $stable(adc_channel) [*4]; endproperty
  a_slot: assert property (p_slot) else $error("slot too short");
  property p_cycle; $rose(busy) |-> ##[1:1000] adc_channel == 3'h4; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle too long");
  property p_drain; !alert_oe_n |-> !alert_out; endproperty
  a_drain: assert property (p_drain) else $error("alert pin driven high");
  property p_irq; irq |-> !alert_oe_n; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without alert");
  property p_ready; psel && !penable |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no answer in access cycle");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
endmodule
bind voltage_temp_monitor_sequencer vtm_checker u_vtm_checker (.sys_clk, .rstn, .psel,
  .penable, .pready, .irq, .adc_channel, .busy, .alert_out, .alert_oe_n);
`default_nettype wire

// *** verification/vtm_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vtm_defs.vh"
module vtm_far_side (
  input  wire logic [2:0]  adc_channel,
  input  wire logic [54:0] codes,
  output logic      [10:0] adc_code,
  output logic             scl,
  output logic             sda,
  output logic             add
);
  logic [1:0] strap = `ADDSEL_GND;
  // No channel beyond 4 exists, so nothing valid is offered there
  assign adc_code = adc_channel > 3'h4 ? 11'h7FF : codes[adc_channel * 11 +: 11];
  assign add = strap == `ADDSEL_GND ? 1'b0 : strap == `ADDSEL_VCC ? 1'b1 :
    strap == `ADDSEL_SDA ? sda : scl;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, one clock, stop; lines rest high on pull-ups between frames
  task frame(input logic [1:0] s);
    strap = s;
    #160;
    sda = 1'b0;
    #80 scl = 1'b0;
    #80 scl = 1'b1;
    #80 sda = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire
